// ---- rtl/spc_port_cfg.sv ----
// Purpose: Serial target port: mode select, config registers and
//          a two-wire target engine that reaches them
// Assumes: scl/sda/strap pins are asynchronous; other inputs ref_clk
// Notes:   SPI framing lives elsewhere; only its data output is muxed
`timescale 1ns/1ps
// Behaviour
// - Rate field steers only pad slew/drive
// - Rate codes map to voltage/speed grades
// - Spike filter on clock and data inputs
// - One bit output delayed 8x field
// - Zero bit output delayed 8x field
// - Acknowledge only matching 7-bit target address
// - Address low bits from OTP or straps
// - Address size bit picks one or two bytes
// - Page bits complete 32-bit CSR address
// - Mode field: off, two-wire, SPI, reserved
// - Status pin becomes SPI data in 4-wire
module spc_port_cfg (
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  input  wire logic        ce,
  input  wire logic        scl_i,
  input  wire logic        sda_i,
  output logic             sda_o,
  output logic             sda_oe,
  input  wire logic [1:0]  strap_i,
  input  wire logic        strap_en,
  input  wire logic [1:0]  otp_addr_lo,
  input  wire logic [31:0] page_base,
  input  wire logic        spi_3wire,
  input  wire logic        spi_sdo,
  input  wire logic        status_bit,
  output logic             sdo_o,
  output logic             sdo_oe,
  output logic [1:0]       slew_grade,
  output logic [1:0]       port_mode,
  output logic             addr_two_byte,
  output logic [31:0]      csr_addr
);
  import spc_pkg::*;

  logic             scl_s1_q, scl_s2_q, sda_s1_q, sda_s2_q;
  logic [1:0]       strap_s1_q, strap_s2_q;
  logic             scl_p_q, sda_p_q;
  logic [1:0]       rate_q, mode_q, cap_cnt_q;
  logic [3:0]       fltr_q, one_dly_q, zero_dly_q, bitcnt_q;
  logic [6:0]       taddr_q, dly_q;
  logic             asize_q, cap_done_q;
  spc_state_t       st_q;
  logic [7:0]       sh_q, tx_q, ahi_q, wr_data_q, rd_next;
  logic [31:0]      ptr_q, wr_addr_q;
  logic             rw_q, first_q, more_q, nack_q, wr_q;
  logic             req_q, req_bit_q, pend_v_q, pend_bit_q;
  logic             sda_o_q, sda_oe_q, sdo_o_q, sdo_oe_q;
  logic [1:0]       slew_q;
  logic             scl_c, sda_c, rise, fall, start, stop;

  spc_fltr_if scl_if ();
  spc_fltr_if sda_if ();

  // ---------------------------------------------------------------
  // Input synchronisers and spike filters
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      scl_s1_q   <= 1'b1;
      scl_s2_q   <= 1'b1;
      sda_s1_q   <= 1'b1;
      sda_s2_q   <= 1'b1;
      strap_s1_q <= 2'h0;
      strap_s2_q <= 2'h0;
    end else if (ce) begin
      scl_s1_q   <= scl_i;
      scl_s2_q   <= scl_s1_q;
      sda_s1_q   <= sda_i;
      sda_s2_q   <= sda_s1_q;
      strap_s1_q <= strap_i;
      strap_s2_q <= strap_s1_q;
    end
  end

  assign scl_if.raw = scl_s2_q;
  assign scl_if.len = fltr_q;
  assign sda_if.raw = sda_s2_q;
  assign sda_if.len = fltr_q;

  spc_glitch_fltr u_scl_fltr (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .ce      (ce),
    .fif     (scl_if.filt)
  );

  spc_glitch_fltr u_sda_fltr (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .ce      (ce),
    .fif     (sda_if.filt)
  );

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      scl_p_q <= 1'b1;
      sda_p_q <= 1'b1;
    end else if (ce) begin
      scl_p_q <= scl_c;
      sda_p_q <= sda_c;
    end
  end

  assign scl_c = scl_if.clean;
  assign sda_c = sda_if.clean;
  assign rise  = scl_c & ~scl_p_q;
  assign fall  = ~scl_c & scl_p_q;
  assign start = scl_c & scl_p_q & sda_p_q & ~sda_c;
  assign stop  = scl_c & scl_p_q & ~sda_p_q & sda_c;

  // ---------------------------------------------------------------
  // Register readback and address forming
  // ---------------------------------------------------------------
  function automatic logic [7:0] rd_reg(input logic [31:0] a);
    // Unmapped locations read as zero, as do reserved bits
    if (a == SPC_BASE + OFF_RATE) begin
      rd_reg = {2'h0, rate_q, fltr_q};
    end else if (a == SPC_BASE + OFF_DELAY) begin
      rd_reg = {one_dly_q, zero_dly_q};
    end else if (a == SPC_BASE + OFF_TADDR) begin
      rd_reg = {1'b0, taddr_q};
    end else if (a == SPC_BASE + OFF_GLOBAL) begin
      rd_reg = {5'h00, asize_q, mode_q};
    end else begin
      rd_reg = 8'h00;
    end
  endfunction

  function automatic logic [31:0] mk_addr(input logic [7:0] hi,
                                          input logic [7:0] lo);
    if (asize_q) begin
      mk_addr = {page_base[31:16], hi, lo};
    end else begin
      mk_addr = {page_base[31:8], lo};
    end
  endfunction

  assign rd_next = rd_reg(ptr_q + 32'h1);

  // ---------------------------------------------------------------
  // Two-wire target engine
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q      <= ST_IDLE;
      bitcnt_q  <= 4'h0;
      sh_q      <= 8'h00;
      tx_q      <= 8'h00;
      ahi_q     <= 8'h00;
      ptr_q     <= 32'h0;
      rw_q      <= 1'b0;
      first_q   <= 1'b0;
      more_q    <= 1'b0;
      nack_q    <= 1'b0;
      wr_q      <= 1'b0;
      wr_addr_q <= 32'h0;
      wr_data_q <= 8'h00;
      req_q     <= 1'b0;
      req_bit_q <= 1'b1;
    end else if (ce) begin
      req_q <= 1'b0;
      wr_q  <= 1'b0;
      if (mode_q != MODE_I2C || stop) begin
        if (st_q != ST_IDLE) begin
          req_q     <= 1'b1;
          req_bit_q <= 1'b1;
        end
        st_q <= ST_IDLE;
      end else if (start) begin
        st_q     <= ST_DEV;
        bitcnt_q <= 4'h0;
        if (st_q != ST_IDLE) begin
          req_q     <= 1'b1;
          req_bit_q <= 1'b1;
        end
      end else if (rise) begin
        if (st_q == ST_RACK) begin
          nack_q <= sda_c;
        end else if (bitcnt_q < BYTE_BITS) begin
          sh_q     <= {sh_q[6:0], sda_c};
          bitcnt_q <= bitcnt_q + 4'h1;
        end
      end else if (fall) begin
        req_q     <= 1'b1;
        req_bit_q <= 1'b1;
        case (st_q)
          ST_DEV: begin
            if (bitcnt_q != BYTE_BITS) begin
              req_q <= 1'b0;
            end else if (sh_q[7:1] == taddr_q) begin
              rw_q      <= sh_q[0];
              req_bit_q <= 1'b0;
              st_q      <= ST_ACK_DEV;
            end else begin
              req_q <= 1'b0;
              st_q  <= ST_IDLE;
            end
          end
          ST_ACK_DEV: begin
            bitcnt_q <= 4'h0;
            if (rw_q) begin
              tx_q      <= rd_reg(ptr_q);
              req_bit_q <= rd_reg(ptr_q) >> 7 != 8'h00;
              st_q      <= ST_RD;
            end else begin
              first_q <= 1'b1;
              st_q    <= ST_REG;
            end
          end
          ST_REG: begin
            if (bitcnt_q != BYTE_BITS) begin
              req_q <= 1'b0;
            end else begin
              more_q    <= asize_q & first_q;
              first_q   <= 1'b0;
              ahi_q     <= sh_q;
              if (!(asize_q & first_q)) begin
                ptr_q <= mk_addr(ahi_q, sh_q);
              end
              req_bit_q <= 1'b0;
              st_q      <= ST_ACK_REG;
            end
          end
          ST_ACK_REG: begin
            bitcnt_q <= 4'h0;
            st_q     <= more_q ? ST_REG : ST_WR;
          end
          ST_WR: begin
            if (bitcnt_q != BYTE_BITS) begin
              req_q <= 1'b0;
            end else begin
              wr_q      <= 1'b1;
              wr_addr_q <= ptr_q;
              wr_data_q <= sh_q;
              ptr_q     <= ptr_q + 32'h1;
              req_bit_q <= 1'b0;
              st_q      <= ST_ACK_WR;
            end
          end
          ST_ACK_WR: begin
            bitcnt_q <= 4'h0;
            st_q     <= ST_WR;
          end
          ST_RD: begin
            if (bitcnt_q == BYTE_BITS) begin
              st_q <= ST_RACK;
            end else begin
              tx_q      <= {tx_q[6:0], 1'b0};
              req_bit_q <= tx_q[6];
            end
          end
          ST_RACK: begin
            if (nack_q) begin
              st_q <= ST_IDLE;
            end else begin
              ptr_q     <= ptr_q + 32'h1;
              tx_q      <= rd_next;
              req_bit_q <= rd_next[7];
              bitcnt_q  <= 4'h0;
              st_q      <= ST_RD;
            end
          end
          default: begin
            req_q <= 1'b0;
          end
        endcase
      end
    end
  end

  // ---------------------------------------------------------------
  // Output delay after the clock falls; set by register alone, so the
  // rate grade never bends protocol timing
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pend_v_q   <= 1'b0;
      pend_bit_q <= 1'b1;
      dly_q      <= 7'h00;
      sda_o_q    <= 1'b0;
      sda_oe_q   <= 1'b0;
    end else if (ce) begin
      sda_o_q <= 1'b0;
      if (mode_q != MODE_I2C) begin
        // Leaving two-wire mode drops any pending pull at once
        pend_v_q <= 1'b0;
        sda_oe_q <= 1'b0;
      end else if (req_q) begin
        pend_v_q   <= 1'b1;
        pend_bit_q <= req_bit_q;
        if (req_bit_q) begin
          dly_q <= {one_dly_q, 3'h0};
        end else begin
          dly_q <= {zero_dly_q, 3'h0};
        end
      end else if (pend_v_q) begin
        if (dly_q == 7'h00) begin
          sda_oe_q <= ~pend_bit_q;
          pend_v_q <= 1'b0;
        end else begin
          dly_q <= dly_q - 7'h01;
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // Configuration registers and strap capture
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rate_q     <= RST_RATE;
      fltr_q     <= RST_FLTR;
      one_dly_q  <= RST_ONE_DLY;
      zero_dly_q <= RST_ZERO_DLY;
      taddr_q    <= RST_TADDR;
      asize_q    <= RST_ASIZE;
      mode_q     <= RST_MODE;
      cap_cnt_q  <= 2'h0;
      cap_done_q <= 1'b0;
    end else if (ce) begin
      if (!cap_done_q) begin
        cap_cnt_q <= cap_cnt_q + 2'h1;
        if (cap_cnt_q == STRAP_CAP_CYC) begin
          // Straps settle through the synchroniser before capture
          taddr_q[1:0] <= strap_en ? strap_s2_q : otp_addr_lo;
          cap_done_q   <= 1'b1;
        end
      end
      if (wr_q) begin
        if (wr_addr_q == SPC_BASE + OFF_RATE) begin
          rate_q <= wr_data_q[RATE_LSB +: 2];
          fltr_q <= wr_data_q[FLTR_LSB +: 4];
        end else if (wr_addr_q == SPC_BASE + OFF_DELAY) begin
          one_dly_q  <= wr_data_q[ONE_DLY_LSB +: 4];
          zero_dly_q <= wr_data_q[ZERO_DLY_LSB +: 4];
        end else if (wr_addr_q == SPC_BASE + OFF_TADDR) begin
          taddr_q[6:2] <= wr_data_q[6:2];
        end else if (wr_addr_q == SPC_BASE + OFF_GLOBAL) begin
          asize_q <= wr_data_q[ASIZE_BIT];
          mode_q  <= wr_data_q[MODE_LSB +: 2];
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // Pad controls and status pin
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      slew_q   <= RATE_STD;
      sdo_o_q  <= 1'b0;
      sdo_oe_q <= 1'b0;
    end else if (ce) begin
      // Reserved grade falls back to the weakest drive
      slew_q <= (rate_q == RATE_RSVD) ? RATE_STD : rate_q;
      sdo_oe_q <= (mode_q == MODE_I2C) || (mode_q == MODE_SPI);
      if (mode_q == MODE_SPI && !spi_3wire) begin
        sdo_o_q <= spi_sdo;
      end else begin
        sdo_o_q <= status_bit;
      end
    end
  end

  assign sda_o         = sda_o_q;
  assign sda_oe        = sda_oe_q;
  assign sdo_o         = sdo_o_q;
  assign sdo_oe        = sdo_oe_q;
  assign slew_grade    = slew_q;
  assign port_mode     = mode_q;
  assign addr_two_byte = asize_q;
  assign csr_addr      = ptr_q;

endmodule

// ---- rtl/spc_pkg.sv ----
// Purpose: Shared constants and types for the serial port config block
// Assumes: 8-bit configuration registers, 250 MHz system clock
// Notes:   Register offsets are relative to SPC_BASE in the CSR space
package spc_pkg;

  // ---------------------------------------------------------------
  // Port modes and rate grades
  // ---------------------------------------------------------------
  localparam logic [1:0] MODE_OFF      = 2'h0;
  localparam logic [1:0] MODE_I2C      = 2'h1;
  localparam logic [1:0] MODE_SPI      = 2'h2;
  localparam logic [1:0] RATE_STD      = 2'h0;
  localparam logic [1:0] RATE_FAST_LV  = 2'h1;
  localparam logic [1:0] RATE_RSVD     = 2'h2;
  localparam logic [1:0] RATE_FPLUS    = 2'h3;

  // ---------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------
  localparam logic [31:0] SPC_BASE     = 32'h0000_0100;
  localparam logic [31:0] OFF_RATE     = 32'h0000_0000;
  localparam logic [31:0] OFF_DELAY    = 32'h0000_0001;
  localparam logic [31:0] OFF_TADDR    = 32'h0000_0002;
  localparam logic [31:0] OFF_GLOBAL   = 32'h0000_0003;

  // Field positions
  localparam int RATE_LSB      = 4;
  localparam int FLTR_LSB      = 0;
  localparam int ONE_DLY_LSB   = 4;
  localparam int ZERO_DLY_LSB  = 0;
  localparam int ASIZE_BIT     = 2;
  localparam int MODE_LSB      = 0;

  // Values after reset
  localparam logic [1:0] RST_RATE      = 2'h0;
  localparam logic [3:0] RST_FLTR      = 4'h1;
  localparam logic [3:0] RST_ONE_DLY   = 4'h4;
  localparam logic [3:0] RST_ZERO_DLY  = 4'h4;
  localparam logic [6:0] RST_TADDR     = 7'h09;
  localparam logic       RST_ASIZE     = 1'b0;
  localparam logic [1:0] RST_MODE      = 2'h1;

  // Cycle counts
  localparam logic [1:0] STRAP_CAP_CYC = 2'h3;
  localparam logic [3:0] BYTE_BITS     = 4'h8;

  typedef enum logic [3:0] {
    ST_IDLE, ST_DEV, ST_ACK_DEV, ST_REG, ST_ACK_REG,
    ST_WR, ST_ACK_WR, ST_RD, ST_RACK
  } spc_state_t;

endpackage

// ---- rtl/spc_fltr_if.sv ----
// Purpose: Carrier between the port logic and one glitch filter
// Assumes: All signals on ref_clk
// Notes:   One instance per filtered input
`timescale 1ns/1ps
interface spc_fltr_if;
  logic [3:0] len;
  logic       raw;
  logic       clean;
  modport filt (input len, input raw, output clean);
  modport user (output len, output raw, input clean);
endinterface

// ---- rtl/spc_glitch_fltr.sv ----
// Purpose: Digital spike filter for one synchronised input
// Assumes: raw already passed a two-stage synchroniser
// Notes:   Length zero passes the input with one flop of latency
`timescale 1ns/1ps
module spc_glitch_fltr (
  input  wire logic   ref_clk,
  input  wire logic   rst_n,
  input  wire logic   ce,
  spc_fltr_if.filt    fif
);
  import spc_pkg::*;

  logic [3:0] cnt_q;
  logic       clean_q;

  assign fif.clean = clean_q;

  // ---------------------------------------------------------------
  // Accept a new level only after it held for len cycles
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q   <= 4'h0;
      clean_q <= 1'b1;
    end else if (ce) begin
      if (fif.raw == clean_q) begin
        cnt_q <= 4'h0;
      end else if ((cnt_q + 4'h1) >= fif.len) begin
        clean_q <= fif.raw;
        cnt_q   <= 4'h0;
      end else begin
        cnt_q <= cnt_q + 4'h1;
      end
    end
  end

endmodule

// ---- tb/spc_port_cfg_props.sv ----
// Purpose: Port-level checks for spc_port_cfg
// Assumes: One ref_clk domain, asynchronous active-low reset
// Notes:   Bound to every spc_port_cfg instance
`timescale 1ns/1ps
module spc_port_cfg_props (
  input wire logic        ref_clk,
  input wire logic        rst_n,
  input wire logic        ce,
  input wire logic        scl_i,
  input wire logic        sda_i,
  input wire logic        sda_o,
  input wire logic        sda_oe,
  input wire logic [1:0]  strap_i,
  input wire logic        strap_en,
  input wire logic [1:0]  otp_addr_lo,
  input wire logic [31:0] page_base,
  input wire logic        spi_3wire,
  input wire logic        spi_sdo,
  input wire logic        status_bit,
  input wire logic        sdo_o,
  input wire logic        sdo_oe,
  input wire logic [1:0]  slew_grade,
  input wire logic [1:0]  port_mode,
  input wire logic        addr_two_byte,
  input wire logic [31:0] csr_addr
);
  import spc_pkg::*;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  // Counts cycles of an idle bus; config writes must not land there
  logic [7:0] idle_q;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      idle_q <= 8'h00;
    end else if (!(scl_i && sda_i)) begin
      idle_q <= 8'h00;
    end else if (idle_q != 8'hFF) begin
      idle_q <= idle_q + 8'h01;
    end
  end

  // Attempts start only on enabled edges out of reset: on the edge that
  // lifts reset the flops still take their reset values
  AST_SDO_MUX: assert property (
    rst_n && ce |=> sdo_o ==
      (($past(port_mode) == MODE_SPI && !$past(spi_3wire))
      ? $past(spi_sdo) : $past(status_bit)))
    else $error("status pin does not follow the mode mux");
  AST_SDO_OE: assert property (
    rst_n && ce |=> sdo_oe == ($past(port_mode) == MODE_I2C
      || $past(port_mode) == MODE_SPI))
    else $error("status pin enable does not match the mode");
  AST_OPEN_DRAIN: assert property (!sda_o)
    else $error("data pin driven high");
  AST_SLEW_LEGAL: assert property (slew_grade != RATE_RSVD)
    else $error("reserved pad grade reached the pads");
  AST_OFF_RELEASE: assert property (
    (port_mode != MODE_I2C) [*8] |-> !sda_oe)
    else $error("data pin pulled outside two-wire mode");
  AST_PULL_AFTER_FALL: assert property (
    $rose(sda_oe) |-> !$past(scl_i, 4))
    else $error("zero bit driven without a preceding clock fall");
  AST_REL_AFTER_FALL: assert property (
    $fell(sda_oe) && !scl_i |-> !$past(scl_i, 4))
    else $error("one bit released without a preceding clock fall");
  AST_CFG_QUIET: assert property (
    idle_q > 8'h28 |-> $stable(port_mode) && $stable(slew_grade)
      && $stable(addr_two_byte))
    else $error("configuration changed on an idle bus");

  COV_ACK: cover property ($rose(sda_oe));
  COV_SPI: cover property (port_mode == MODE_SPI);
  COV_TWO: cover property (addr_two_byte);
endmodule

bind spc_port_cfg spc_port_cfg_props i_props (
  .ref_clk(ref_clk), .rst_n(rst_n), .ce(ce), .scl_i(scl_i),
  .sda_i(sda_i), .sda_o(sda_o), .sda_oe(sda_oe), .strap_i(strap_i),
  .strap_en(strap_en), .otp_addr_lo(otp_addr_lo),
  .page_base(page_base), .spi_3wire(spi_3wire), .spi_sdo(spi_sdo),
  .status_bit(status_bit), .sdo_o(sdo_o), .sdo_oe(sdo_oe),
  .slew_grade(slew_grade), .port_mode(port_mode),
  .addr_two_byte(addr_two_byte), .csr_addr(csr_addr)
);

// ---- tb/spc_i2c_ctrl.sv ----
// Purpose: Two-wire bus controller model facing the target port
// Assumes: sda is the resolved wire with its pull-up
// Notes:   Low phase is lo + 10 ns, high phase 40 ns
`timescale 1ns/1ps
module spc_i2c_ctrl (
  output logic      scl,
  output logic      sda_pull,
  input  wire logic sda
);
  // Stretching the low phase lets the long default output delays
  // land before the controller samples
  int lo = 30;

  initial begin
    scl = 1'b1;
    sda_pull = 1'b0;
  end

  task automatic clk_bit(input logic b, output logic s);
    #10 sda_pull = !b;
    #(lo) scl = 1'b1;
    #20 s = sda;
    #20 scl = 1'b0;
  endtask

  // Odd offset keeps pin edges away from the system clock edges
  task automatic start();
    #1.37 sda_pull = 1'b0;
    #(10 + lo) scl = 1'b1;
    #20 sda_pull = 1'b1;
    #20 scl = 1'b0;
  endtask

  task automatic stop();
    #10 sda_pull = 1'b1;
    #(lo) scl = 1'b1;
    #20 sda_pull = 1'b0;
    #20;
  endtask

  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) clk_bit(d[i], s);
    clk_bit(1'b1, s);
    ack = !s;
  endtask

  task automatic rbyte(input logic nack, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) clk_bit(1'b1, d[i]);
    clk_bit(nack, s);
  endtask
endmodule

// ---- tb/tb_spc_port_cfg.sv ----
// Purpose: Self-checking bench for spc_port_cfg
// Assumes: Controller model drives the bus; data line pulled up
// Notes:   Low phase is stretched while delay fields are large
`timescale 1ns/1ps
module tb_spc_port_cfg;
  import spc_pkg::*;
  localparam logic [15:0] A_RATE  = 16'(SPC_BASE + OFF_RATE);
  localparam logic [15:0] A_DLY   = 16'(SPC_BASE + OFF_DELAY);
  localparam logic [15:0] A_TADDR = 16'(SPC_BASE + OFF_TADDR);
  localparam logic [15:0] A_GLB   = 16'(SPC_BASE + OFF_GLOBAL);
  logic        ref_clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        scl;
  logic        ctl_pull;
  logic        sda;
  logic        sda_o;
  logic        sda_oe;
  logic [1:0]  otp_lo = 2'h1;
  logic [31:0] page = 32'h0000_0100;
  logic        spi_3w = 1'b0;
  logic        spi_sdo = 1'b0;
  logic        status_bit = 1'b1;
  logic        strap_sel = 1'b0;
  logic        sdo_o;
  logic        sdo_oe;
  logic [1:0]  slew;
  logic [1:0]  mode;
  logic        two_b;
  logic [31:0] csr;
  logic [6:0]  dev = 7'h09;
  logic        scl_q;
  logic        oe_q;
  int          cnt;
  int          d_pull;
  int          d_rel;
  int          n_fail = 0;
  int          num_checks = 0;

  always #2 ref_clk = !ref_clk;
  assign sda = !(ctl_pull || sda_oe);

  spc_port_cfg i_dut (
    .ref_clk(ref_clk), .rst_n(rst_n), .ce(1'b1), .scl_i(scl),
    .sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe), .strap_i(2'h2),
    .strap_en(strap_sel), .otp_addr_lo(otp_lo), .page_base(page),
    .spi_3wire(spi_3w), .spi_sdo(spi_sdo), .status_bit(status_bit),
    .sdo_o(sdo_o), .sdo_oe(sdo_oe), .slew_grade(slew),
    .port_mode(mode), .addr_two_byte(two_b), .csr_addr(csr)
  );
  spc_i2c_ctrl i_ctl (.scl(scl), .sda_pull(ctl_pull), .sda(sda));

  // Cycles from the last clock-pin fall to each data-pin change
  always @(posedge ref_clk) begin
    scl_q <= scl;
    oe_q <= sda_oe;
    cnt <= (scl_q && !scl) ? 0 : cnt + 1;
    if (sda_oe && !oe_q) d_pull <= cnt;
    if (!sda_oe && oe_q) d_rel <= cnt;
  end

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      n_fail++;
      $display("unexpected %s: expected %h, seen %h", nm, e, g);
    end
  endtask

  task automatic do_reset();
    @(posedge ref_clk) rst_n <= 1'b0;
    repeat (4) @(posedge ref_clk);
    rst_n <= 1'b1;
    repeat (12) @(posedge ref_clk);
    i_ctl.lo = 230;
    dev = 7'h09;
  endtask

  task automatic hdr(input logic [15:0] a, input logic two);
    logic k;
    i_ctl.start();
    i_ctl.wbyte({dev, 1'b0}, k);
    chk("addr ack", 32'h1, 32'(k));
    if (two) i_ctl.wbyte(a[15:8], k);
    i_ctl.wbyte(a[7:0], k);
    chk("reg ack", 32'h1, 32'(k));
  endtask

  task automatic wr(input logic [15:0] a, input logic [7:0] d,
                    input logic two);
    logic k;
    hdr(a, two);
    i_ctl.wbyte(d, k);
    i_ctl.stop();
  endtask

  task automatic rchk(input string nm, input logic [15:0] a,
                      input logic two, input logic [7:0] e);
    logic       k;
    logic [7:0] d;
    hdr(a, two);
    i_ctl.start();
    i_ctl.wbyte({dev, 1'b1}, k);
    i_ctl.rbyte(1'b1, d);
    i_ctl.stop();
    chk(nm, 32'(e), 32'(d));
  endtask

  task automatic t_defaults();
    chk("mode", 32'(MODE_I2C), 32'(mode));
    chk("asize", 32'h0, 32'(two_b));
    chk("slew", 32'(RATE_STD), 32'(slew));
    chk("status pin", 32'h1, 32'(sdo_o));
    rchk("rate", A_RATE, 1'b0, 8'h01);
    rchk("delays", A_DLY, 1'b0, 8'h44);
    rchk("taddr", A_TADDR, 1'b0, 8'h09);
    rchk("global", A_GLB, 1'b0, 8'h01);
  endtask

  // Only differences are judged: the sync and filter latency cancels
  task automatic t_delays();
    int   p3;
    int   r1;
    logic k;
    wr(A_DLY, 8'h13, 1'b0);
    hdr(A_DLY, 1'b0);
    p3 = d_pull;
    r1 = d_rel;
    i_ctl.wbyte(8'h31, k);
    i_ctl.stop();
    hdr(A_DLY, 1'b0);
    chk("zero delay step", 32'h10, 32'(p3 - d_pull));
    chk("one delay step", 32'h10, 32'(d_rel - r1));
    i_ctl.wbyte(8'h00, k);
    i_ctl.stop();
    i_ctl.lo = 30;
  endtask

  task automatic t_rate();
    logic [1:0] c;
    for (int i = 0; i < 4; i++) begin
      c = 2'(i);
      // Filter length follows the code, so zero (no filtering) runs too
      wr(A_RATE, {2'h3, c, 2'h0, c}, 1'b0);
      chk("slew", 32'(c == RATE_RSVD ? RATE_STD : c), 32'(slew));
      rchk("rate", A_RATE, 1'b0, {2'h0, c, 2'h0, c});
    end
  endtask

  task automatic t_addr();
    logic k;
    wr(A_TADDR, 8'hFC, 1'b0);
    i_ctl.start();
    i_ctl.wbyte(8'h12, k);
    i_ctl.stop();
    chk("old addr ack", 32'h0, 32'(k));
    dev = {5'h1F, otp_lo};
    rchk("taddr", A_TADDR, 1'b0, {1'b0, dev});
  endtask

  task automatic t_ptr();
    logic k;
    wr(A_GLB, 8'hFD, 1'b0);
    chk("asize", 32'h1, 32'(two_b));
    rchk("global", A_GLB, 1'b1, 8'h05);
    @(posedge ref_clk) page <= 32'h5A5A_0100;
    hdr(16'h0102, 1'b1);
    chk("csr addr", 32'h5A5A_0102, csr);
    i_ctl.wbyte(8'h77, k);
    i_ctl.stop();
    rchk("unmapped", 16'h0102, 1'b1, 8'h00);
    @(posedge ref_clk) page <= 32'h0000_0100;
    wr(A_GLB, 8'h01, 1'b1);
    chk("asize", 32'h0, 32'(two_b));
  endtask

  task automatic t_modes();
    wr(A_GLB, 8'h00, 1'b0);
    repeat (3) @(posedge ref_clk);
    chk("mode", 32'(MODE_OFF), 32'(mode));
    chk("status oe", 32'h0, 32'(sdo_oe));
    do_reset();
    wr(A_GLB, 8'h02, 1'b0);
    chk("mode", 32'(MODE_SPI), 32'(mode));
    @(posedge ref_clk) spi_sdo <= 1'b1;
    status_bit <= 1'b0;
    repeat (3) @(posedge ref_clk);
    #1 chk("spi data out", 32'h1, 32'(sdo_o));
    @(posedge ref_clk) spi_3w <= 1'b1;
    repeat (3) @(posedge ref_clk);
    #1 chk("status pin", 32'h0, 32'(sdo_o));
    // Straps are captured once after reset, so the select goes first
    @(posedge ref_clk) strap_sel <= 1'b1;
    do_reset();
    dev = {5'h02, 2'h2};
    rchk("strap taddr", A_TADDR, 1'b0, 8'h0A);
  endtask

  task automatic close_out();
    $display("checks %0d, mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  initial begin
    do_reset();
    t_defaults();
    t_delays();
    t_rate();
    t_addr();
    t_ptr();
    t_modes();
    close_out();
  end
endmodule
